// file: rtl/pbdmux_defs.vh
// constants for the port b / port d alternate function override block
`ifndef PBDMUX_DEFS_VH
`define PBDMUX_DEFS_VH
`define PBD_PB_W 8
`define PBD_PD_W 7
`define PBD_PB_SCL 7
`define PBD_PB_DO 6
`define PBD_PB_SDA 5
`define PBD_PB_CMP1B 4
`define PBD_PB_CMP1A 3
`define PBD_PB_CMP0A 2
`define PBD_PB_ACN 1
`define PBD_PB_ACP 0
`define PBD_PD_CAP 6
`define PBD_PD_ECLK1 5
`define PBD_PD_ECLK0 4
`define PBD_PD_EXT1 3
`define PBD_PD_EXT0 2
`define PBD_PD_TX 1
`define PBD_PD_RX 0
`endif

// file: rtl/pbdmux_pin.v
// one pad's override resolution and input synchroniser
`timescale 1ns/1ps
module pbdmux_pin (
    clk,
    rst_n,
    dir_bit,
    port_bit,
    global_pullup_disable,
    sleep_input_disable,
    pullup_override_enable,
    pullup_override_value,
    direction_override_enable,
    direction_override_value,
    value_override_enable,
    value_override_value,
    toggle_override_enable,
    input_enable_override_enable,
    input_enable_override_value,
    pad_in,
    pad_out,
    pad_oe,
    pad_pullup,
    port_bit_next,
    din_raw,
    din_sync
);
    input wire clk;
    input wire rst_n;
    input wire dir_bit;
    input wire port_bit;
    input wire global_pullup_disable;
    input wire sleep_input_disable;
    input wire pullup_override_enable;
    input wire pullup_override_value;
    input wire direction_override_enable;
    input wire direction_override_value;
    input wire value_override_enable;
    input wire value_override_value;
    input wire toggle_override_enable;
    input wire input_enable_override_enable;
    input wire input_enable_override_value;
    input wire pad_in;
    output wire pad_out;
    output wire pad_oe;
    output wire pad_pullup;
    output wire port_bit_next;
    output wire din_raw;
    output reg din_sync;

    reg s1_q;
    reg s2_q;
    reg s3_q;
    wire in_en;

    // ----------------------------------------------------------------
    // override resolution
    // ----------------------------------------------------------------
    assign pad_pullup = pullup_override_enable ? pullup_override_value :
        (~dir_bit & port_bit & ~global_pullup_disable);
    assign pad_oe = direction_override_enable ? direction_override_value :
        dir_bit;
    assign pad_out = value_override_enable ? value_override_value :
        port_bit;
    assign port_bit_next = port_bit ^ toggle_override_enable;
    // input gate: override wins over sleep
    assign in_en = input_enable_override_enable ?
        input_enable_override_value : ~sleep_input_disable;
    // raw level is unsynchronised; clock-type users resync it themselves
    assign din_raw = pad_in & in_en;

    // ----------------------------------------------------------------
    // three-stage synchroniser, change taken when stages 2 and 3 agree
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= 1'h0;
            s2_q <= 1'h0;
            s3_q <= 1'h0;
            din_sync <= 1'h0;
        end else begin
            s1_q <= din_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                din_sync <= s3_q;
            end
        end
    end
endmodule // pbdmux_pin

// file: rtl/pbdmux_top.v
// port b and port d alternate function override mux
`timescale 1ns/1ps
`include "pbdmux_defs.vh"
module pbdmux_top #(
    parameter PB_W = `PBD_PB_W,
    parameter PD_W = `PBD_PD_W
) (
    clk,
    rst_n,
    portb_dir,
    portb_val,
    portd_dir,
    portd_val,
    global_pullup_disable,
    sleep_input_disable,
    pin_change_mask,
    pin_change_group_enable,
    timer1_compare_a_out,
    timer1_compare_a_en,
    timer1_compare_b_out,
    timer1_compare_b_en,
    timer0_compare_a_out,
    timer0_compare_a_en,
    timer0_compare_b_out,
    timer0_compare_b_en,
    timer1_control_cs,
    timer0_control_cs,
    input_capture_enable,
    ext_interrupt_zero_enable,
    ext_interrupt_one_enable,
    usart_sync_clock_out,
    usart_sync_clock_drive,
    system_clock_out,
    system_clock_out_enable,
    usart_tx_enable,
    usart_tx_data,
    usart_rx_enable,
    serial_if_2wire_mode,
    serial_if_3wire_mode,
    serial_if_clock_hold,
    serial_if_clock_toggle,
    serial_if_start_irq_enable,
    serial_if_data_out,
    serial_if_sda_out,
    portb_pad_in,
    portb_pad_out,
    portb_pad_oe,
    portb_pullup,
    portd_pad_in,
    portd_pad_out,
    portd_pad_oe,
    portd_pullup,
    portb_val_next,
    portd_val_next,
    portb_pin_sync,
    portd_pin_sync,
    pin_change_source,
    timer1_ext_clock_in,
    timer0_ext_clock_in,
    input_capture_pin,
    ext_interrupt_zero_pin,
    ext_interrupt_one_pin,
    usart_sync_clock_in,
    usart_rx_data,
    serial_if_clock_in,
    serial_if_data_in
);
    input wire clk;
    input wire rst_n;
    input wire [PB_W-1:0] portb_dir;
    input wire [PB_W-1:0] portb_val;
    input wire [PD_W-1:0] portd_dir;
    input wire [PD_W-1:0] portd_val;
    input wire global_pullup_disable;
    input wire sleep_input_disable;
    input wire [PB_W-1:0] pin_change_mask;
    input wire pin_change_group_enable;
    input wire timer1_compare_a_out;
    input wire timer1_compare_a_en;
    input wire timer1_compare_b_out;
    input wire timer1_compare_b_en;
    input wire timer0_compare_a_out;
    input wire timer0_compare_a_en;
    input wire timer0_compare_b_out;
    input wire timer0_compare_b_en;
    input wire [2:0] timer1_control_cs;
    input wire [2:0] timer0_control_cs;
    input wire input_capture_enable;
    input wire ext_interrupt_zero_enable;
    input wire ext_interrupt_one_enable;
    input wire usart_sync_clock_out;
    input wire usart_sync_clock_drive;
    input wire system_clock_out;
    input wire system_clock_out_enable;
    input wire usart_tx_enable;
    input wire usart_tx_data;
    input wire usart_rx_enable;
    input wire serial_if_2wire_mode;
    input wire serial_if_3wire_mode;
    input wire serial_if_clock_hold;
    input wire serial_if_clock_toggle;
    input wire serial_if_start_irq_enable;
    input wire serial_if_data_out;
    input wire serial_if_sda_out;
    input wire [PB_W-1:0] portb_pad_in;
    output wire [PB_W-1:0] portb_pad_out;
    output wire [PB_W-1:0] portb_pad_oe;
    output wire [PB_W-1:0] portb_pullup;
    input wire [PD_W-1:0] portd_pad_in;
    output wire [PD_W-1:0] portd_pad_out;
    output wire [PD_W-1:0] portd_pad_oe;
    output wire [PD_W-1:0] portd_pullup;
    output wire [PB_W-1:0] portb_val_next;
    output wire [PD_W-1:0] portd_val_next;
    output wire [PB_W-1:0] portb_pin_sync;
    output wire [PD_W-1:0] portd_pin_sync;
    output wire [PB_W-1:0] pin_change_source;
    output wire timer1_ext_clock_in;
    output wire timer0_ext_clock_in;
    output wire input_capture_pin;
    output wire ext_interrupt_zero_pin;
    output wire ext_interrupt_one_pin;
    output wire usart_sync_clock_in;
    output wire usart_rx_data;
    output wire serial_if_clock_in;
    output wire serial_if_data_in;

    // per-pin override vectors: pullup, direction, value, toggle, input
    reg [PB_W-1:0] b_pue, b_puv, b_dde, b_ddv, b_pve, b_pvv;
    reg [PB_W-1:0] b_pte, b_ine, b_inl;
    reg [PD_W-1:0] d_pue, d_puv, d_dde, d_ddv, d_pve, d_pvv;
    reg [PD_W-1:0] d_pte, d_ine, d_inl;
    wire [PB_W-1:0] b_raw;
    wire [PD_W-1:0] d_raw;
    wire t1_clk_en;
    wire t0_clk_en;
    wire sclk_in_en;

    assign t1_clk_en = timer1_control_cs[2] & timer1_control_cs[1];
    assign t0_clk_en = timer0_control_cs[2] & timer0_control_cs[1];
    // usart clock input wanted while receiving without driving it
    assign sclk_in_en = ~usart_sync_clock_drive & usart_rx_enable;

    // ----------------------------------------------------------------
    // port b override table
    // ----------------------------------------------------------------
    always @* begin
        b_pue = {PB_W{1'b0}};
        b_puv = {PB_W{1'b0}};
        b_dde = {PB_W{1'b0}};
        b_ddv = {PB_W{1'b0}};
        b_pve = {PB_W{1'b0}};
        b_pvv = {PB_W{1'b0}};
        b_pte = {PB_W{1'b0}};
        b_inl = {PB_W{1'b1}};
        b_ine = pin_change_mask & {PB_W{pin_change_group_enable}};
        // two-wire: pin drives only low, enabled while low, scl also while holding
        b_dde[`PBD_PB_SCL] = serial_if_2wire_mode;
        b_ddv[`PBD_PB_SCL] = (serial_if_clock_hold | ~portb_val[`PBD_PB_SCL])
            & portb_dir[`PBD_PB_SCL];
        b_pve[`PBD_PB_SCL] = serial_if_2wire_mode
            & portb_dir[`PBD_PB_SCL];
        b_pte[`PBD_PB_SCL] = serial_if_clock_toggle;
        b_ine[`PBD_PB_SCL] = b_ine[`PBD_PB_SCL]
            | serial_if_start_irq_enable;
        b_dde[`PBD_PB_SDA] = serial_if_2wire_mode;
        b_ddv[`PBD_PB_SDA] = (~serial_if_sda_out | ~portb_val[`PBD_PB_SDA])
            & portb_dir[`PBD_PB_SDA];
        b_pve[`PBD_PB_SDA] = serial_if_2wire_mode
            & portb_dir[`PBD_PB_SDA];
        b_ine[`PBD_PB_SDA] = b_ine[`PBD_PB_SDA]
            | serial_if_start_irq_enable;
        // three-wire data out: value only, direction/pullup untouched
        b_pve[`PBD_PB_DO] = serial_if_3wire_mode;
        b_pvv[`PBD_PB_DO] = serial_if_data_out;
        b_pve[`PBD_PB_CMP1B] = timer1_compare_b_en;
        b_pvv[`PBD_PB_CMP1B] = timer1_compare_b_out;
        // compare outputs reach the pad only when the direction bit is set,
        // as the value override never touches the driver enable
        b_pve[`PBD_PB_CMP1A] = timer1_compare_a_en;
        b_pvv[`PBD_PB_CMP1A] = timer1_compare_a_out;
        b_pve[`PBD_PB_CMP0A] = timer0_compare_a_en;
        b_pvv[`PBD_PB_CMP0A] = timer0_compare_a_out;
    end

    // ----------------------------------------------------------------
    // port d override table
    // ----------------------------------------------------------------
    always @* begin
        d_pue = {PD_W{1'b0}};
        d_puv = {PD_W{1'b0}};
        d_dde = {PD_W{1'b0}};
        d_ddv = {PD_W{1'b0}};
        d_pve = {PD_W{1'b0}};
        d_pvv = {PD_W{1'b0}};
        d_pte = {PD_W{1'b0}};
        d_ine = {PD_W{1'b0}};
        d_inl = {PD_W{1'b1}};
        d_ine[`PBD_PD_CAP] = input_capture_enable;
        d_pve[`PBD_PD_ECLK1] = timer0_compare_b_en;
        d_pvv[`PBD_PD_ECLK1] = timer0_compare_b_out;
        d_ine[`PBD_PD_ECLK1] = t1_clk_en;
        d_ine[`PBD_PD_ECLK0] = t0_clk_en;
        d_ine[`PBD_PD_EXT1] = ext_interrupt_one_enable;
        d_ine[`PBD_PD_EXT0] = ext_interrupt_zero_enable | sclk_in_en;
        // system clock out has priority over the usart clock
        d_pve[`PBD_PD_EXT0] = system_clock_out_enable
            | usart_sync_clock_drive;
        d_pvv[`PBD_PD_EXT0] = system_clock_out_enable ? system_clock_out :
            usart_sync_clock_out;
        d_pue[`PBD_PD_TX] = usart_tx_enable;
        d_dde[`PBD_PD_TX] = usart_tx_enable;
        d_ddv[`PBD_PD_TX] = usart_tx_enable;
        d_pve[`PBD_PD_TX] = usart_tx_enable;
        d_pvv[`PBD_PD_TX] = usart_tx_data;
        d_inl[`PBD_PD_TX] = 1'b0;
        d_pue[`PBD_PD_RX] = usart_rx_enable;
        d_puv[`PBD_PD_RX] = portd_val[`PBD_PD_RX] & ~global_pullup_disable;
        d_dde[`PBD_PD_RX] = usart_rx_enable;
        d_inl[`PBD_PD_RX] = 1'b0;
    end

    // ----------------------------------------------------------------
    // pad instances
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < PB_W; gi = gi + 1) begin : g_pb
            pbdmux_pin u_pin (
                .clk(clk),
                .rst_n(rst_n),
                .dir_bit(portb_dir[gi]),
                .port_bit(portb_val[gi]),
                .global_pullup_disable(global_pullup_disable),
                .sleep_input_disable(sleep_input_disable),
                .pullup_override_enable(b_pue[gi]),
                .pullup_override_value(b_puv[gi]),
                .direction_override_enable(b_dde[gi]),
                .direction_override_value(b_ddv[gi]),
                .value_override_enable(b_pve[gi]),
                .value_override_value(b_pvv[gi]),
                .toggle_override_enable(b_pte[gi]),
                .input_enable_override_enable(b_ine[gi]),
                .input_enable_override_value(b_inl[gi]),
                .pad_in(portb_pad_in[gi]),
                .pad_out(portb_pad_out[gi]),
                .pad_oe(portb_pad_oe[gi]),
                .pad_pullup(portb_pullup[gi]),
                .port_bit_next(portb_val_next[gi]),
                .din_raw(b_raw[gi]),
                .din_sync(portb_pin_sync[gi])
            );
        end
        for (gi = 0; gi < PD_W; gi = gi + 1) begin : g_pd
            pbdmux_pin u_pin (
                .clk(clk),
                .rst_n(rst_n),
                .dir_bit(portd_dir[gi]),
                .port_bit(portd_val[gi]),
                .global_pullup_disable(global_pullup_disable),
                .sleep_input_disable(sleep_input_disable),
                .pullup_override_enable(d_pue[gi]),
                .pullup_override_value(d_puv[gi]),
                .direction_override_enable(d_dde[gi]),
                .direction_override_value(d_ddv[gi]),
                .value_override_enable(d_pve[gi]),
                .value_override_value(d_pvv[gi]),
                .toggle_override_enable(d_pte[gi]),
                .input_enable_override_enable(d_ine[gi]),
                .input_enable_override_value(d_inl[gi]),
                .pad_in(portd_pad_in[gi]),
                .pad_out(portd_pad_out[gi]),
                .pad_oe(portd_pad_oe[gi]),
                .pad_pullup(portd_pullup[gi]),
                .port_bit_next(portd_val_next[gi]),
                .din_raw(d_raw[gi]),
                .din_sync(portd_pin_sync[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // digital inputs to peripherals (raw; each peripheral syncs itself)
    // ----------------------------------------------------------------
    assign pin_change_source = b_raw;
    assign timer1_ext_clock_in = d_raw[`PBD_PD_ECLK1];
    assign timer0_ext_clock_in = d_raw[`PBD_PD_ECLK0];
    assign input_capture_pin = d_raw[`PBD_PD_CAP];
    assign ext_interrupt_one_pin = d_raw[`PBD_PD_EXT1];
    assign ext_interrupt_zero_pin = d_raw[`PBD_PD_EXT0];
    assign usart_sync_clock_in = d_raw[`PBD_PD_EXT0];
    // receive data bypasses the input gate that is shut for sleep
    assign usart_rx_data = portd_pad_in[`PBD_PD_RX];
    assign serial_if_clock_in = b_raw[`PBD_PB_SCL];
    assign serial_if_data_in = b_raw[`PBD_PB_SDA];
endmodule // pbdmux_top

// file: testbench/pbdmux_asserts.sv
// concurrent checks on the pad side of the override mux
`timescale 1ns/1ps
module pbdmux_asserts #(
    parameter PB_W = 8,
    parameter PD_W = 7
) (
    input logic clk,
    input logic rst_n,
    input logic [PB_W-1:0] portb_dir,
    input logic [PB_W-1:0] portb_val,
    input logic global_pullup_disable,
    input logic sleep_input_disable,
    input logic [PB_W-1:0] pin_change_mask,
    input logic pin_change_group_enable,
    input logic timer1_compare_a_out,
    input logic timer1_compare_a_en,
    input logic timer0_compare_b_out,
    input logic timer0_compare_b_en,
    input logic input_capture_enable,
    input logic ext_interrupt_one_enable,
    input logic usart_tx_enable,
    input logic usart_tx_data,
    input logic serial_if_2wire_mode,
    input logic [PB_W-1:0] portb_pad_in,
    input logic [PD_W-1:0] portd_pad_in,
    input logic [PB_W-1:0] portb_pad_out,
    input logic [PB_W-1:0] portb_pad_oe,
    input logic [PB_W-1:0] portb_pullup,
    input logic [PD_W-1:0] portd_pad_out,
    input logic [PD_W-1:0] portd_pad_oe,
    input logic [PD_W-1:0] portd_pullup,
    input logic [PB_W-1:0] portb_pin_sync,
    input logic [PB_W-1:0] pin_change_source,
    input logic input_capture_pin,
    input logic ext_interrupt_one_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // the synchroniser needs several quiet edges before it may be judged
    sequence s_pads_quiet;
        (!sleep_input_disable && $stable(portb_pad_in)) [*7];
    endsequence
    a_cmp1a_path: assert property (portb_dir[3] && timer1_compare_a_en
        |-> portb_pad_out[3] == timer1_compare_a_out) else $error("pb3 wave");
    a_cmp0b_path: assert property (portd_pad_oe[5]
        && timer0_compare_b_en |-> portd_pad_out[5] == timer0_compare_b_out)
        else $error("pd5 wave");
    a_oe_follow: assert property (!serial_if_2wire_mode
        |-> portb_pad_oe == portb_dir) else $error("pb oe not dir");
    a_pullup_b: assert property (portb_pullup ==
        (~portb_dir & portb_val & {PB_W{!global_pullup_disable}}))
        else $error("pb pull-up");
    a_pin_change_source_gate: assert property (pin_change_group_enable |->
        ((pin_change_source ^ portb_pad_in) & pin_change_mask) == '0)
        else $error("pin change gate");
    a_capture_in: assert property (input_capture_enable
        |-> input_capture_pin == portd_pad_in[6]) else $error("capture in");
    a_ext_one: assert property (ext_interrupt_one_pin ==
        (portd_pad_in[3] & (ext_interrupt_one_enable | !sleep_input_disable)))
        else $error("ext int one");
    a_tx_force: assert property (usart_tx_enable |-> portd_pad_oe[1]
        && portd_pad_out[1] == usart_tx_data && !portd_pullup[1])
        else $error("tx pin");
    a_twowire_low: assert property (serial_if_2wire_mode
        && portb_pad_oe[7] |-> !portb_pad_out[7]) else $error("scl not low");
    a_sync_follow: assert property (s_pads_quiet
        |-> portb_pin_sync == portb_pad_in) else $error("sync lags");
endmodule // pbdmux_asserts

bind pbdmux_top pbdmux_asserts #(.PB_W(PB_W), .PD_W(PD_W)) i_chk (.clk,
    .rst_n, .portb_dir, .portb_val, .global_pullup_disable,
    .sleep_input_disable, .pin_change_mask, .pin_change_group_enable,
    .timer1_compare_a_out, .timer1_compare_a_en, .timer0_compare_b_out,
    .timer0_compare_b_en, .input_capture_enable, .ext_interrupt_one_enable,
    .usart_tx_enable, .usart_tx_data, .serial_if_2wire_mode, .portb_pad_in,
    .portd_pad_in, .portb_pad_out, .portb_pad_oe, .portb_pullup,
    .portd_pad_out, .portd_pad_oe, .portd_pullup, .portb_pin_sync,
    .pin_change_source, .input_capture_pin, .ext_interrupt_one_pin);

// file: testbench/pbdmux_pads.sv
// board model that resolves each pad from all drivers
`timescale 1ns/1ps
module pbdmux_pads #(
    parameter int W = 8
) (
    input logic clk,
    input logic [W-1:0] oe,
    input logic [W-1:0] drv,
    input logic [W-1:0] pu,
    input logic [W-1:0] ext_en,
    input logic [W-1:0] ext_val,
    output logic [W-1:0] pad
);
    // an open pin without pull-up wanders, so it must never read stable
    logic float_q = 1'b0;
    always @(posedge clk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe[i]) pad[i] = drv[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (pu[i]) pad[i] = 1'b1;
            else pad[i] = float_q ^ i[0];
        end
    end
endmodule // pbdmux_pads

// file: testbench/pbdmux_top_tb.sv
// self-checking bench for the port b / port d override mux
`timescale 1ns/1ps
module pbdmux_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] portb_dir, portb_val, pin_change_mask, pb_ext_en, pb_ext_val;
    logic [6:0] portd_dir, portd_val, pd_ext_en, pd_ext_val;
    logic [2:0] timer1_control_cs, timer0_control_cs;
    logic global_pullup_disable, sleep_input_disable, pin_change_group_enable,
        timer1_compare_a_out, timer1_compare_a_en, timer1_compare_b_out,
        timer1_compare_b_en, timer0_compare_a_out, timer0_compare_a_en,
        timer0_compare_b_out, timer0_compare_b_en, input_capture_enable,
        ext_interrupt_zero_enable, ext_interrupt_one_enable,
        usart_sync_clock_out, usart_sync_clock_drive, system_clock_out,
        system_clock_out_enable, usart_tx_enable, usart_tx_data,
        usart_rx_enable, serial_if_2wire_mode, serial_if_3wire_mode,
        serial_if_clock_hold, serial_if_clock_toggle,
        serial_if_start_irq_enable, serial_if_data_out, serial_if_sda_out;
    wire [7:0] portb_pad_in, portb_pad_out, portb_pad_oe, portb_pullup,
        portb_val_next, portb_pin_sync, pin_change_source;
    wire [6:0] portd_pad_in, portd_pad_out, portd_pad_oe, portd_pullup,
        portd_val_next, portd_pin_sync;
    wire timer1_ext_clock_in, timer0_ext_clock_in, input_capture_pin,
        ext_interrupt_zero_pin, ext_interrupt_one_pin, usart_sync_clock_in,
        usart_rx_data, serial_if_clock_in, serial_if_data_in;
    int fails = 0;
    int cmp_count = 0;

    pbdmux_top i_dut (.clk, .rst_n, .portb_dir, .portb_val, .portd_dir,
        .portd_val, .global_pullup_disable, .sleep_input_disable,
        .pin_change_mask, .pin_change_group_enable, .timer1_compare_a_out,
        .timer1_compare_a_en, .timer1_compare_b_out, .timer1_compare_b_en,
        .timer0_compare_a_out, .timer0_compare_a_en, .timer0_compare_b_out,
        .timer0_compare_b_en, .timer1_control_cs, .timer0_control_cs,
        .input_capture_enable, .ext_interrupt_zero_enable,
        .ext_interrupt_one_enable, .usart_sync_clock_out,
        .usart_sync_clock_drive, .system_clock_out, .system_clock_out_enable,
        .usart_tx_enable, .usart_tx_data, .usart_rx_enable,
        .serial_if_2wire_mode, .serial_if_3wire_mode, .serial_if_clock_hold,
        .serial_if_clock_toggle, .serial_if_start_irq_enable,
        .serial_if_data_out, .serial_if_sda_out, .portb_pad_in, .portb_pad_out,
        .portb_pad_oe, .portb_pullup, .portd_pad_in, .portd_pad_out,
        .portd_pad_oe, .portd_pullup, .portb_val_next, .portd_val_next,
        .portb_pin_sync, .portd_pin_sync, .pin_change_source,
        .timer1_ext_clock_in, .timer0_ext_clock_in, .input_capture_pin,
        .ext_interrupt_zero_pin, .ext_interrupt_one_pin, .usart_sync_clock_in,
        .usart_rx_data, .serial_if_clock_in, .serial_if_data_in);
    pbdmux_pads #(.W(8)) i_pb (.clk, .oe(portb_pad_oe), .drv(portb_pad_out),
        .pu(portb_pullup), .ext_en(pb_ext_en), .ext_val(pb_ext_val),
        .pad(portb_pad_in));
    pbdmux_pads #(.W(7)) i_pd (.clk, .oe(portd_pad_oe), .drv(portd_pad_out),
        .pu(portd_pullup), .ext_en(pd_ext_en), .ext_val(pd_ext_val),
        .pad(portd_pad_in));

    always #5 clk = ~clk;

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic rest;
        {portb_dir, portb_val, pin_change_mask, pb_ext_en, pb_ext_val} = '0;
        {portd_dir, portd_val, pd_ext_en, pd_ext_val} = '0;
        {timer1_control_cs, timer0_control_cs} = '0;
        {global_pullup_disable, sleep_input_disable, pin_change_group_enable,
            timer1_compare_a_out, timer1_compare_a_en, timer1_compare_b_out,
            timer1_compare_b_en, timer0_compare_a_out, timer0_compare_a_en,
            timer0_compare_b_out, timer0_compare_b_en, input_capture_enable,
            ext_interrupt_zero_enable, ext_interrupt_one_enable,
            usart_sync_clock_out, usart_sync_clock_drive, system_clock_out,
            system_clock_out_enable, usart_tx_enable, usart_tx_data,
            usart_rx_enable, serial_if_2wire_mode, serial_if_3wire_mode,
            serial_if_clock_hold, serial_if_clock_toggle,
            serial_if_start_irq_enable, serial_if_data_out,
            serial_if_sda_out} = '0;
    endtask

    task automatic t_compare;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            rest;
            portb_dir = k[1] ? 8'h1C : 8'h00;
            portd_dir = k[1] ? 7'h20 : 7'h00;
            portb_val = k[0] ? 8'h00 : 8'hFF;
            {timer1_compare_a_en, timer1_compare_b_en, timer0_compare_a_en,
                timer0_compare_b_en} = 4'hF;
            {timer1_compare_a_out, timer1_compare_b_out, timer0_compare_a_out,
                timer0_compare_b_out} = {4{k[0]}};
            #1;
            chk(portb_pad_oe[3] === k[1], "pb3 oe");
            chk(!k[1] || portb_pad_out[3] === k[0], "pb3 wave");
            chk(portb_pad_oe[2] === k[1], "pb2 oe");
            chk(!k[1] || portb_pad_out[2] === k[0], "pb2 wave");
            chk(!k[1] || portd_pad_out[5] === k[0], "pd5 wave");
        end
        $display("t_compare done");
    endtask

    task automatic t_usart;
        for (int p = 0; p < 2; p++) begin
            @(negedge clk);
            rest;
            global_pullup_disable = p[0];
            portb_dir = 8'h30;
            portb_val = 8'hF0; // comparator pins input, pull-up off
            {portd_dir, portd_val} = 14'h0083;
            {usart_rx_enable, usart_tx_enable, usart_tx_data} = {2'h3, p[0]};
            #1;
            chk(portb_pullup === (p ? 8'h00 : 8'hC0), "pb pull-up");
            chk(portd_pad_oe[0] === 1'b0, "rx dir");
            chk(portd_pullup[0] === !p, "rx pull-up");
            chk(usart_rx_data === portd_pad_in[0], "rx data");
            chk(portd_pad_out[1] === p[0], "tx data");
        end
        $display("t_usart done");
    endtask

    task automatic t_inputs;
        for (int e = 0; e < 3; e++) begin
            @(negedge clk);
            rest;
            {pb_ext_en, pb_ext_val, pd_ext_en, pd_ext_val} = '1;
            sleep_input_disable = (e < 2);
            pin_change_mask = 8'hFF;
            {pin_change_group_enable, input_capture_enable} = {2{e == 1}};
            {ext_interrupt_zero_enable, ext_interrupt_one_enable} = {2{e == 1}};
            serial_if_start_irq_enable = (e == 1);
            timer1_control_cs = (e == 1) ? 3'h6 : 3'h2;
            timer0_control_cs = (e == 1) ? 3'h7 : 3'h4;
            #1;
            chk(pin_change_source === {8{e > 0}}, "pin change");
            chk(timer1_ext_clock_in === (e > 0), "t1 clock");
            chk(timer0_ext_clock_in === (e > 0), "t0 clock");
            chk(input_capture_pin === (e > 0), "capture");
            chk(ext_interrupt_zero_pin === (e > 0), "int 0");
            chk(serial_if_clock_in === (e > 0), "usi clock");
            chk(serial_if_data_in === (e > 0), "usi data");
            chk(usart_sync_clock_in === (e > 0), "xck in");
        end
        $display("t_inputs done");
    endtask

    task automatic t_serial;
        @(negedge clk);
        rest;
        {serial_if_2wire_mode, serial_if_sda_out} = 2'h3;
        {portb_dir, portb_val} = 16'hA0A0;
        #1;
        chk({portb_pad_oe[7], portb_pad_oe[5]} === 2'h0, "2w off");
        chk(portb_val_next[7] === 1'b1, "no toggle");
        @(negedge clk);
        {serial_if_clock_hold, serial_if_clock_toggle} = 2'h3;
        serial_if_sda_out = 1'b0;
        #1;
        chk({portb_pad_oe[7], portb_pad_out[7]} === 2'h2, "hold");
        chk({portb_pad_oe[5], portb_pad_out[5]} === 2'h2, "sda");
        chk(portb_val_next[7] === 1'b0, "toggle");
        @(negedge clk);
        rest;
        {serial_if_3wire_mode, serial_if_data_out} = 2'h3;
        portb_dir = 8'h40;
        #1;
        chk(portb_pad_out[6] === 1'b1, "do out");
        @(negedge clk);
        {portb_dir, portb_val} = 16'h0040;
        #1;
        chk(portb_pullup[6] === 1'b1, "do pull-up");
        $display("t_serial done");
    endtask

    task automatic t_clkout;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            rest;
            portd_dir = 7'h04;
            system_clock_out_enable = k[1];
            usart_sync_clock_drive = 1'b1;
            system_clock_out = k[0] ^ !k[1];
            usart_sync_clock_out = !system_clock_out;
            #1;
            chk(portd_pad_out[2] === k[0], "pd2 clock");
        end
        @(negedge clk);
        rest;
        {pb_ext_en, pb_ext_val, pd_ext_en, pd_ext_val} = 30'h3FF6BFB5;
        repeat (5) @(posedge clk);
        #1;
        chk(portb_pin_sync === 8'hDA, "pb sync");
        chk(portd_pin_sync === 7'h35, "pd sync");
        $display("t_clkout done");
    endtask

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        rest;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_compare;
        t_usart;
        t_inputs;
        t_serial;
        t_clkout;
        close_out;
    end

    // the tests need well under a hundred cycles
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        $display("[FAIL] %0t watchdog", $time);
        close_out;
    end
endmodule // pbdmux_top_tb
